// ---- shared/dcsr_params.svh ----
`ifndef DCSR_PARAMS_SVH
`define DCSR_PARAMS_SVH
`define DCSR_BIT_GO      0
`define DCSR_BIT_FN_LO   1
`define DCSR_BIT_FN_HI   3
`define DCSR_BIT_XA_LO   4
`define DCSR_BIT_XA_HI   5
`define DCSR_BIT_IE      6
`define DCSR_BIT_READY   7
`define DCSR_BIT_CYCLE   8
`define DCSR_BIT_ST_LO   9
`define DCSR_BIT_ST_HI   11
`define DCSR_BIT_MAINTENANCE_BIT   12
`define DCSR_BIT_ATTENTION_FLAG    13
`define DCSR_BIT_NEX     14
`define DCSR_BIT_ERROR   15
`define DCSR_TIMEOUT_NS  20000
`define DCSR_CLK_NS      50
`define DCSR_TIMEOUT_CYC (`DCSR_TIMEOUT_NS / `DCSR_CLK_NS)
`endif

// ---- shared/dcsr_pkg.sv ----
package dcsr_pkg;
    // Write request from the processor side
    typedef struct packed {
        logic        wr_lo;
        logic        wr_hi;
        logic [15:0] data;
    } dcsr_wr_t;
    // Bus-master phases watched by the reply timer
    typedef enum logic [2:0] {
        DCSR_IDLE = 3'b001,
        DCSR_WAIT = 3'b010,
        DCSR_RMW  = 3'b100
    } dcsr_state_t;
endpackage : dcsr_pkg

// ---- logic/dcsr_top.sv ----
`timescale 1ns/100ps
`include "dcsr_params.svh"
module dcsr_top #(
    parameter int TIMEOUT_CYC = `DCSR_TIMEOUT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire dcsr_pkg::dcsr_wr_t wr,
    output logic [15:0]            rd_data,
    input  wire logic              attention_in,
    input  wire logic [2:0]        device_status_inputs,
    input  wire logic              cycle_request,
    input  wire logic              cycle_done,
    input  wire logic              word_count_overflow,
    input  wire logic              addr_wrap,
    input  wire logic              extended_addressing_mode,
    input  wire logic              indep_irq_enable,
    input  wire logic              master_start,
    input  wire logic              master_reply,
    input  wire logic              rmw_read_done,
    input  wire logic              rmw_write_start,
    output logic [2:0]             user_function_bits,
    output logic                   ready_to_user,
    output logic                   irq_req,
    output logic [1:0]             upper_address_bits,
    output logic                   cycle_flag,
    output logic                   maintenance_bit_out
);
    initial begin
        if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535)
            $error("TIMEOUT_CYC out of range");
    end

    logic [2:0]  fn_reg;
    logic [1:0]  xa_reg;
    logic        ie_reg;
    logic        ready_reg;
    logic        cycle_reg;
    logic        maintenance_bit_reg;
    logic        nex_reg;
    logic        err_prev_reg;
    logic [15:0] tmr_reg;
    dcsr_pkg::dcsr_state_t st_reg;
    logic        error;
    logic        timeout;
    logic        go_wr;

    // Error is derived, never stored
    assign error = nex_reg | attention_in;
    assign timeout = (tmr_reg == 16'(TIMEOUT_CYC - 1));
    assign go_wr = wr.wr_lo & wr.data[`DCSR_BIT_GO];

    // User function bits, low byte lane
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            fn_reg <= 3'h0;
        else if (wr.wr_lo)
            fn_reg <= wr.data[`DCSR_BIT_FN_HI:`DCSR_BIT_FN_LO];
    end

    // Upper address: writable only outside extended mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            xa_reg <= 2'h0;
        else if (!extended_addressing_mode) begin
            if (wr.wr_lo)
                xa_reg <= wr.data[`DCSR_BIT_XA_HI:`DCSR_BIT_XA_LO];
            else if (addr_wrap)
                xa_reg <= xa_reg + 2'h1;
        end
    end

    // Interrupt enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ie_reg <= 1'b0;
        else if (wr.wr_lo)
            ie_reg <= wr.data[`DCSR_BIT_IE];
    end

    // Ready: sets win over the launch clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ready_reg <= 1'b1;
        else if (word_count_overflow || error)
            ready_reg <= 1'b1;
        else if (go_wr)
            ready_reg <= 1'b0;
    end

    // Cycle flag, high byte lane; request wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cycle_reg <= 1'b0;
        else if (cycle_request)
            cycle_reg <= 1'b1;
        else if (wr.wr_hi)
            cycle_reg <= wr.data[`DCSR_BIT_CYCLE];
        else if (cycle_done)
            cycle_reg <= 1'b0;
    end

    // Maintenance bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            maintenance_bit_reg <= 1'b0;
        else if (wr.wr_hi)
            maintenance_bit_reg <= wr.data[`DCSR_BIT_MAINTENANCE_BIT];
    end

    // Reply timer for bus-master and read-modify-write phases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg  <= dcsr_pkg::DCSR_IDLE;
            tmr_reg <= 16'h0000;
        end else begin
            unique case (st_reg)
                dcsr_pkg::DCSR_IDLE: begin
                    tmr_reg <= 16'h0000;
                    if (rmw_read_done)
                        st_reg <= dcsr_pkg::DCSR_RMW;
                    else if (master_start)
                        st_reg <= dcsr_pkg::DCSR_WAIT;
                end
                dcsr_pkg::DCSR_WAIT: begin
                    tmr_reg <= tmr_reg + 16'h0001;
                    if (master_reply || timeout)
                        st_reg <= dcsr_pkg::DCSR_IDLE;
                end
                dcsr_pkg::DCSR_RMW: begin
                    tmr_reg <= tmr_reg + 16'h0001;
                    if (rmw_write_start || timeout)
                        st_reg <= dcsr_pkg::DCSR_IDLE;
                end
                default: begin
                    st_reg  <= dcsr_pkg::DCSR_IDLE;
                    tmr_reg <= 16'h0000;
                end
            endcase
        end
    end

    // Nonexistent memory: timeout set wins over a zero write
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            nex_reg <= 1'b0;
        else if (timeout && st_reg != dcsr_pkg::DCSR_IDLE
                 && !(st_reg == dcsr_pkg::DCSR_WAIT && master_reply)
                 && !(st_reg == dcsr_pkg::DCSR_RMW && rmw_write_start))
            nex_reg <= 1'b1;
        else if (wr.wr_hi && !wr.data[`DCSR_BIT_NEX])
            nex_reg <= 1'b0;
    end

    // Interrupt request on ready/error rise or independent attention
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_prev_reg <= 1'b0;
            irq_req      <= 1'b0;
        end else begin
            err_prev_reg <= error;
            irq_req <= ie_reg & ((error & ~err_prev_reg)
                       | (word_count_overflow & ~ready_reg)
                       | (indep_irq_enable & attention_in));
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data            <= 16'h0000;
            user_function_bits <= 3'h0;
            ready_to_user      <= 1'b0;
            upper_address_bits <= 2'h0;
            cycle_flag         <= 1'b0;
            maintenance_bit_out          <= 1'b0;
        end else begin
            rd_data <= {error, nex_reg, attention_in, maintenance_bit_reg,
                        device_status_inputs, cycle_reg, ready_reg,
                        ie_reg, xa_reg, fn_reg, 1'b0};
            user_function_bits <= fn_reg;
            ready_to_user      <= go_wr;
            upper_address_bits <= xa_reg;
            cycle_flag         <= cycle_reg;
            maintenance_bit_out          <= maintenance_bit_reg;
        end
    end

    chk_error_or: assert property (@(posedge clk) disable iff (rst)
        rd_data[`DCSR_BIT_ERROR] == (rd_data[`DCSR_BIT_NEX]
                                   | rd_data[`DCSR_BIT_ATTENTION_FLAG]))
        else $error("error bit not OR of causes");
    chk_go_reads_zero: assert property (@(posedge clk) disable iff (rst)
        !rd_data[`DCSR_BIT_GO])
        else $error("launch bit read nonzero");
    chk_ready_on_err: assert property (@(posedge clk) disable iff (rst)
        error |=> ready_reg)
        else $error("ready not set by error");
    chk_go_clears: assert property (@(posedge clk) disable iff (rst)
        go_wr && !error && !word_count_overflow |=> !ready_reg)
        else $error("launch did not clear ready");
    chk_nex_timeout: assert property (@(posedge clk) disable iff (rst)
        timeout && st_reg == dcsr_pkg::DCSR_WAIT && !master_reply
        |=> nex_reg)
        else $error("no timeout after missing reply");
    chk_rmw_timeout: assert property (@(posedge clk) disable iff (rst)
        timeout && st_reg == dcsr_pkg::DCSR_RMW && !rmw_write_start
        |=> nex_reg)
        else $error("no timeout after late write phase");
    chk_nex_quiet: assert property (@(posedge clk) disable iff (rst)
        !nex_reg && !timeout |=> !nex_reg)
        else $error("nonexistent flag set without timeout");
    chk_nex_hold: assert property (@(posedge clk) disable iff (rst)
        nex_reg && !wr.wr_hi |=> nex_reg)
        else $error("nonexistent flag lost");
    chk_fn_out: assert property (@(posedge clk) disable iff (rst)
        wr.wr_lo |=> ##1 user_function_bits == $past(wr.data[3:1], 2))
        else $error("function bits not presented");
    chk_attention_flag_irq: assert property (@(posedge clk) disable iff (rst)
        ie_reg && indep_irq_enable && attention_in |=> irq_req)
        else $error("no independent interrupt");
    chk_xa_ro: assert property (@(posedge clk) disable iff (rst)
        extended_addressing_mode |=> $stable(xa_reg))
        else $error("upper address changed in extended mode");
    chk_cycle_req: assert property (@(posedge clk) disable iff (rst)
        cycle_request |=> ##1 cycle_flag)
        else $error("cycle not set by request");
endmodule : dcsr_top

// ---- sim/dcsr_user_model.sv ----
`timescale 1ns/100ps
// User device: turns bench commands into registered user-side levels
module dcsr_user_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       attention_flag_cmd,
    input  wire logic [2:0] stat_cmd,
    input  wire logic       cyc_cmd,
    output logic            attention_in,
    output logic [2:0]      device_status_inputs,
    output logic            cycle_request
);
    // Lines change only after a clock edge, as real user logic would
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            attention_in         <= 1'b0;
            device_status_inputs <= 3'h0;
            cycle_request        <= 1'b0;
        end else begin
            attention_in         <= attention_flag_cmd;
            device_status_inputs <= stat_cmd;
            cycle_request        <= cyc_cmd;
        end
    end
endmodule : dcsr_user_model

// ---- sim/dcsr_top_bench.sv ----
`timescale 1ns/100ps
module dcsr_top_bench;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    dcsr_pkg::dcsr_wr_t wr = '0;
    logic [15:0]        rd_data, m;
    logic [2:0]         user_function_bits, device_status_inputs;
    logic [1:0]         upper_address_bits;
    logic               ready_to_user, irq_req, cycle_flag, maintenance_bit_out;
    logic               attention_in, cycle_request;
    logic [6:0]         pv = '0;
    logic               xm = 1'b0, ind = 1'b0, attention_flag = 1'b0, cyc = 1'b0;
    logic [2:0]         stat = '0;
    logic [17:0]        q[$], n;
    logic [31:0]        r = 32'h0001_38BF;
    int                 bad_count = 0, num_checks = 0;
    int                 launches = 0, go_exp = 0;
    event               look;

    always #25 clk = ~clk;

    dcsr_top #(.TIMEOUT_CYC(8)) dut (.clk(clk), .rst(rst), .wr(wr),
        .rd_data(rd_data), .attention_in(attention_in),
        .device_status_inputs(device_status_inputs),
        .cycle_request(cycle_request), .cycle_done(pv[0]),
        .word_count_overflow(pv[1]), .addr_wrap(pv[2]),
        .extended_addressing_mode(xm), .indep_irq_enable(ind),
        .master_start(pv[3]), .master_reply(pv[4]),
        .rmw_read_done(pv[5]), .rmw_write_start(pv[6]),
        .user_function_bits(user_function_bits),
        .ready_to_user(ready_to_user), .irq_req(irq_req),
        .upper_address_bits(upper_address_bits),
        .cycle_flag(cycle_flag), .maintenance_bit_out(maintenance_bit_out));

    dcsr_user_model um (.clk(clk), .rst(rst), .attention_flag_cmd(attention_flag),
        .stat_cmd(stat), .cyc_cmd(cyc), .attention_in(attention_in),
        .device_status_inputs(device_status_inputs),
        .cycle_request(cycle_request));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #5;
    endtask : step

    task automatic pulse(input int i);
        pv[i] = 1'b1;
        step(1);
        pv[i] = 1'b0;
    endtask : pulse

    // Register write; m follows what the register should now hold
    task automatic wr_csr(input logic lo, hi, input logic [15:0] d);
        wr = '{wr_lo: lo, wr_hi: hi, data: d};
        step(1);
        wr = '0;
        if (lo) begin
            m[3:1] = d[3:1];
            m[6] = d[6];
            if (!xm) m[5:4] = d[5:4];
            if (d[0]) m[7] = 1'b0;
            go_exp += int'(d[0]);
        end
        if (hi) begin
            m[8] = d[8];
            m[12] = d[12];
            if (!d[14]) m[14] = 1'b0;
        end
    endtask : wr_csr

    // Let things settle, then queue the expected image
    task automatic note(input logic ci, irq);
        step(4);
        m[13] = attention_flag;
        m[11:9] = stat;
        m[15] = m[14] | m[13];
        if (m[15]) m[7] = 1'b1;
        q.push_back({ci, irq, m});
        -> look;
    endtask : note

    task automatic done_test(input string nm);
        $display("test %s done", nm);
    endtask : done_test

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Output watcher: compares each result with the oldest note
    always @(look) begin
        n = q.pop_front();
        chk("rd_data", rd_data, n[15:0]);
        chk("copies", 16'({cycle_flag, maintenance_bit_out, upper_address_bits,
            user_function_bits}), 16'({n[8], n[12], n[5:4], n[3:1]}));
        if (n[17]) chk("irq_req", 16'(irq_req), 16'(n[16]));
    end

    // Launch pulses seen by the user side
    always @(posedge clk) if (ready_to_user === 1'b1) launches++;

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        step(3);
        rst = 1'b0;
        m = 16'h0080;
        note(1, 0);
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            xm = r[20];
            stat = r[23:21];
            wr_csr(r[16], r[17], r[15:0]);
            note(1, 0);
        end
        xm = 1'b0;
        wr_csr(1, 1, 16'h0000);
        done_test("random");
        for (int i = 0; i < 5; i++) begin
            pulse(2);
            m[5:4] = m[5:4] + 2'h1;
        end
        note(1, 0);
        xm = 1'b1;
        pulse(2);
        wr_csr(1, 0, 16'h0030);
        note(1, 0);
        xm = 1'b0;
        cyc = 1'b1;
        step(1);
        cyc = 1'b0;
        m[8] = 1'b1;
        note(1, 0);
        pulse(0);
        m[8] = 1'b0;
        note(1, 0);
        wr_csr(1, 0, 16'h0041);
        note(1, 0);
        pulse(1);
        m[7] = 1'b1;
        note(0, 0);
        done_test("fields");
        ind = 1'b1;
        wr_csr(1, 0, 16'h0041);
        attention_flag = 1'b1;
        note(1, 1);
        wr_csr(1, 0, 16'h0041);
        note(1, 1);
        attention_flag = 1'b0;
        note(1, 0);
        ind = 1'b0;
        wr_csr(1, 1, 16'h0000);
        attention_flag = 1'b1;
        note(1, 0);
        attention_flag = 1'b0;
        note(1, 0);
        done_test("attention");
        // Timeouts: plain cycle and read-modify-write, late and in time
        for (int k = 0; k < 4; k++) begin
            wr_csr(1, 0, 16'h0001);
            pulse(k < 2 ? 3 : 5);
            step(4);
            if (k == 3) pulse(6);
            if (k[0]) pulse(4);
            if (!k[0]) step(8);
            m[14] = !k[0];
            note(1, 0);
            wr_csr(0, 1, 16'h4000);
            note(1, 0);
            wr_csr(0, 1, 16'h0000);
            note(1, 0);
        end
        chk("launches", 16'(launches), 16'(go_exp));
        done_test("timeout");
        print_verdict();
    end
endmodule : dcsr_top_bench
